// >>> core/tivec_node_pick.sv
`timescale 1ns/1ps
// Lowest-index pending-and-enabled node wins
module tivec_node_pick
  import tivec_pkg::*;
#(
  parameter int NODES = 16
) (
  input wire logic [NODES-1:0] req,
  input wire logic [NODES-1:0] en,
  output logic hit,
  output logic [6:0] trap_num
);
  logic [NODES-1:0] live;

  assign live = req & en;

  always_comb begin
    hit = 1'b0;
    trap_num = TN_NODE_BASE;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (live[i]) begin
        hit = 1'b1;
        trap_num = TN_NODE_BASE + 7'(i);
      end
    end
  end
endmodule : tivec_node_pick

// >>> core/tivec_unit.sv
`timescale 1ns/1ps
module tivec_unit
  import tivec_pkg::*;
#(
  parameter int NODES = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  input wire logic watchdog_overflow,
  input wire logic nmi_event,
  input wire logic stack_overflow_event,
  input wire logic stack_underflow_event,
  input wire logic undefined_opcode_event,
  input wire logic protected_fault_event,
  input wire logic illegal_operand_event,
  input wire logic illegal_fetch_event,
  input wire logic illegal_bus_event,
  input wire logic [NODES-1:0] node_event,
  input wire logic service_done,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic branch,
  output logic [8:0] branch_vector,
  output logic [6:0] branch_trap,
  output logic branch_is_trap,
  output logic cpu_reset,
  output logic pec_block,
  output logic irq
);
  logic [15:0] trap_flag_register_ff;
  logic [NODES-1:0] node_req_ff;
  logic [NODES-1:0] node_en_ff;
  logic [2:0] active_pri_ff;
  logic [2:0] saved_pri_ff;
  tivec_state_t state_ff;
  logic [6:0] last_trap_ff;
  logic [IRQ_BITS-1:0] irq_stat_ff;
  logic [IRQ_BITS-1:0] irq_mask_ff;
  logic [15:0] rdata_ff;
  logic branch_ff;
  logic [8:0] branch_vector_ff;
  logic [6:0] branch_trap_ff;
  logic branch_is_trap_ff;
  logic cpu_reset_ff;

  logic [15:0] trap_set;
  logic [2:0] nxt_pri;
  logic [6:0] nxt_trap;
  logic trap_take;
  logic node_hit;
  logic [6:0] node_trap;
  logic node_take;
  logic sw_take;
  logic any_reset;
  logic [3:0] trap_pend_ff;
  logic [3:0] trap_req;
  logic [3:0] nxt_class;

  // NMI and stack faults count as class A; the rest share the class B vector
  assign trap_set = {nmi_event, stack_overflow_event, stack_underflow_event,
                     5'h00, undefined_opcode_event, 3'h0,
                     protected_fault_event, illegal_operand_event,
                     illegal_fetch_event, illegal_bus_event};

  assign any_reset = soft_reset | watchdog_overflow;

  // Event pulses are short, so a refused trap is kept until it can run
  assign trap_req = trap_pend_ff | {nmi_event, stack_overflow_event,
                                    stack_underflow_event,
                                    |(trap_set & CLASS_B_MASK)};

  // Highest pending trap class, fixed priority among classes
  always_comb begin
    nxt_pri = PRI_NONE;
    nxt_trap = TN_RESET;
    nxt_class = 4'h0;
    if (trap_req[3]) begin
      nxt_pri = PRI_NMI;
      nxt_trap = TN_NMI;
      nxt_class = 4'h8;
    end else if (trap_req[2]) begin
      nxt_pri = PRI_STACK_OVERFLOW_FLAG;
      nxt_trap = TN_STACK_OVERFLOW_FLAG;
      nxt_class = 4'h4;
    end else if (trap_req[1]) begin
      nxt_pri = PRI_STACK_UNDERFLOW_FLAG;
      nxt_trap = TN_STACK_UNDERFLOW_FLAG;
      nxt_class = 4'h2;
    end else if (trap_req[0]) begin
      nxt_pri = PRI_CLASS_B;
      nxt_trap = TN_CLASS_B;
      nxt_class = 4'h1;
    end
  end

  // A trap of equal or lower rank than the running one is held back
  assign trap_take = (nxt_pri != PRI_NONE) &&
                     (nxt_pri > active_pri_ff);

  // A reset drops waiting traps along with the running service
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_pend_ff <= '0;
    end else if (any_reset) begin
      trap_pend_ff <= '0;
    end else begin
      trap_pend_ff <= trap_req & ~(trap_take ? nxt_class : '0);
    end
  end

  tivec_node_pick #(
    .NODES(NODES)
  ) u_pick (
    .req(node_req_ff),
    .en(node_en_ff),
    .hit(node_hit),
    .trap_num(node_trap)
  );

  // Nodes wait while any trap service is running
  assign node_take = node_hit && !trap_take && !any_reset &&
                     state_ff == TIVEC_IDLE;
  assign sw_take = wr && addr == REG_SW_TRAP && !trap_take && !any_reset &&
                   !node_take;
  assign pec_block = (active_pri_ff != PRI_NONE);

  // Trap flags: hardware set wins over the software clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_flag_register_ff <= RST_ZERO;
    end else begin
      if (wr && addr == REG_TRAP_FLAGS) begin
        trap_flag_register_ff <= (trap_flag_register_ff & ~wdata) |
                                 trap_set;
      end else begin
        trap_flag_register_ff <= trap_flag_register_ff | trap_set;
      end
    end
  end

  // Node request flags: stick until taken or cleared
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      node_req_ff <= '0;
    end else begin
      for (int i = 0; i < NODES; i++) begin
        if (node_event[i]) begin
          node_req_ff[i] <= 1'b1;
        end else if (node_take && node_trap == TN_NODE_BASE + 7'(i)) begin
          node_req_ff[i] <= 1'b0;
        end else if (wr && addr == REG_NODE_REQ) begin
          node_req_ff[i] <= wdata[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      node_en_ff <= '0;
    end else if (wr && addr == REG_NODE_EN) begin
      node_en_ff <= wdata[NODES-1:0];
    end
  end

  // Service state and priority
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= TIVEC_IDLE;
      active_pri_ff <= PRI_NONE;
      saved_pri_ff <= PRI_NONE;
    end else if (any_reset) begin
      state_ff <= TIVEC_IDLE;
      active_pri_ff <= PRI_NONE;
      saved_pri_ff <= PRI_NONE;
    end else if (trap_take) begin
      state_ff <= TIVEC_TRAP;
      active_pri_ff <= nxt_pri;
      saved_pri_ff <= active_pri_ff;
    end else if (node_take) begin
      state_ff <= TIVEC_IRQ;
    end else if (service_done) begin
      // Single level of nesting is remembered
      active_pri_ff <= saved_pri_ff;
      saved_pri_ff <= PRI_NONE;
      state_ff <= (saved_pri_ff != PRI_NONE) ? TIVEC_TRAP : TIVEC_IDLE;
    end else begin
      case (state_ff)
        TIVEC_IDLE, TIVEC_TRAP, TIVEC_IRQ: state_ff <= state_ff;
        default: state_ff <= TIVEC_IDLE;
      endcase
    end
  end

  // Branch request to the sequencer, one cycle pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      branch_ff <= 1'b0;
      branch_vector_ff <= 9'h000;
      branch_trap_ff <= TN_RESET;
      branch_is_trap_ff <= 1'b0;
      cpu_reset_ff <= 1'b1;
      last_trap_ff <= TN_RESET;
    end else begin
      branch_ff <= any_reset | trap_take | node_take | sw_take;
      cpu_reset_ff <= any_reset;
      branch_is_trap_ff <= trap_take & ~any_reset;
      if (any_reset) begin
        branch_trap_ff <= TN_RESET;
        branch_vector_ff <= tivec_vec(TN_RESET);
        last_trap_ff <= TN_RESET;
      end else if (trap_take) begin
        branch_trap_ff <= nxt_trap;
        branch_vector_ff <= tivec_vec(nxt_trap);
        last_trap_ff <= nxt_trap;
      end else if (node_take) begin
        branch_trap_ff <= node_trap;
        branch_vector_ff <= tivec_vec(node_trap);
        last_trap_ff <= node_trap;
      end else if (sw_take) begin
        // Runs at the current CPU priority: no trap level is raised
        branch_trap_ff <= wdata[6:0];
        branch_vector_ff <= tivec_vec(wdata[6:0]);
        last_trap_ff <= wdata[6:0];
      end
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
                      ~((wr && addr == REG_IRQ_STAT) ?
                        wdata[IRQ_BITS-1:0] : '0)) |
                     {sw_take, node_take, trap_take};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_ff <= '0;
    end else if (wr && addr == REG_IRQ_MASK) begin
      irq_mask_ff <= wdata[IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= RST_ZERO;
    end else if (rd) begin
      case (addr)
        REG_TRAP_FLAGS: rdata_ff <= trap_flag_register_ff;
        REG_NODE_REQ: rdata_ff <= 16'(node_req_ff);
        REG_NODE_EN: rdata_ff <= 16'(node_en_ff);
        REG_VECTOR: rdata_ff <= {7'h00, branch_vector_ff};
        REG_STATUS: rdata_ff <= {5'h00, state_ff, 1'b0, active_pri_ff,
                                 last_trap_ff[3:0]};
        REG_IRQ_STAT: rdata_ff <= 16'(irq_stat_ff);
        REG_IRQ_MASK: rdata_ff <= 16'(irq_mask_ff);
        default: rdata_ff <= RST_ZERO;
      endcase
    end else begin
      rdata_ff <= RST_ZERO;
    end
  end

  assign rdata = rdata_ff;
  assign branch = branch_ff;
  assign branch_vector = branch_vector_ff;
  assign branch_trap = branch_trap_ff;
  assign branch_is_trap = branch_is_trap_ff;
  assign cpu_reset = cpu_reset_ff;

  a_trap_vector_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    nmi_event && active_pri_ff < PRI_NMI && !any_reset |=>
      branch && branch_trap == TN_NMI && branch_vector == 9'h008)
    else $error("NMI did not vector to 0x008");

  a_class_b_vec: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trap_take && nxt_pri == PRI_CLASS_B && !any_reset |=>
      branch_vector == 9'h028 && branch_trap == TN_CLASS_B)
    else $error("Class B trap missed shared vector");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trap_flag_register_ff[FLG_STACK_OVERFLOW_FLAG] && !(wr && addr == REG_TRAP_FLAGS)
      |=> trap_flag_register_ff[FLG_STACK_OVERFLOW_FLAG])
    else $error("Trap flag dropped without clear");

  a_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    illegal_bus_event |=> trap_flag_register_ff[FLG_ILLEGAL_EXTERNAL_BUS_FLAG])
    else $error("Trap flag not set by event");

  a_reset_vector: assert property (@(posedge sys_clk) disable iff (!reset_n)
    any_reset |=> cpu_reset && branch_vector == 9'h000 &&
      $stable(trap_flag_register_ff))
    else $error("Reset vector or flag wrong");

  a_node_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    active_pri_ff != PRI_NONE |-> !node_take && pec_block)
    else $error("Node taken during trap service");

  a_trap_nest: assert property (@(posedge sys_clk) disable iff (!reset_n)
    stack_underflow_event && trap_req[3:2] == 2'b00 &&
      active_pri_ff >= PRI_STACK_UNDERFLOW_FLAG |-> !trap_take)
    else $error("Lower trap pre-empted higher one");

  a_node_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    node_take |-> (node_req_ff & node_en_ff) != '0)
    else $error("Node taken without flag and enable");

  a_node_vector: assert property (@(posedge sys_clk) disable iff (!reset_n)
    node_take && !any_reset |=> branch_vector == {branch_trap, 2'b00} &&
      branch_trap >= TN_NODE_BASE)
    else $error("Node vector not four times trap");

  a_sw_prio: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sw_take && !service_done |=>
      $stable(active_pri_ff) && branch_trap <= TN_MAX)
    else $error("Software trap changed priority");

  a_trap_fast: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trap_take && !any_reset |=> branch && branch_is_trap)
    else $error("Trap not taken next cycle");

  c_nmi_nest: cover property (@(posedge sys_clk) disable iff (!reset_n)
    active_pri_ff == PRI_CLASS_B ##1 trap_take && nxt_pri == PRI_NMI);
  c_node: cover property (@(posedge sys_clk) disable iff (!reset_n)
    node_take);
  c_sw: cover property (@(posedge sys_clk) disable iff (!reset_n)
    sw_take ##1 branch_trap == TN_MAX);
endmodule : tivec_unit

// >>> inc/tivec_pkg.sv
package tivec_pkg;
  // Register offsets (word index; byte address is 4x index)
  localparam logic [3:0] REG_TRAP_FLAGS = 4'h0;
  localparam logic [3:0] REG_NODE_REQ = 4'h1;
  localparam logic [3:0] REG_NODE_EN = 4'h2;
  localparam logic [3:0] REG_SW_TRAP = 4'h3;
  localparam logic [3:0] REG_VECTOR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;

  // Trap flag register bit positions
  localparam int FLG_NMI = 15;
  localparam int FLG_STACK_OVERFLOW_FLAG = 14;
  localparam int FLG_STACK_UNDERFLOW_FLAG = 13;
  localparam int FLG_UNDEFINED_OPCODE_FLAG = 7;
  localparam int FLG_PROTECTED_INSTRUCTION_FAULT_FLAG = 3;
  localparam int FLG_ILLEGAL_WORD_OPERAND_FLAG = 2;
  localparam int FLG_ILLEGAL_INSTRUCTION_FETCH_FLAG = 1;
  localparam int FLG_ILLEGAL_EXTERNAL_BUS_FLAG = 0;
  localparam logic [15:0] CLASS_A_MASK = 16'he000;
  localparam logic [15:0] CLASS_B_MASK = 16'h008f;

  // Trap numbers; vector address = 4 * trap number
  localparam logic [6:0] TN_RESET = 7'h00;
  localparam logic [6:0] TN_NMI = 7'h02;
  localparam logic [6:0] TN_STACK_OVERFLOW_FLAG = 7'h04;
  localparam logic [6:0] TN_STACK_UNDERFLOW_FLAG = 7'h06;
  localparam logic [6:0] TN_CLASS_B = 7'h0a;
  localparam logic [6:0] TN_NODE_BASE = 7'h20;
  localparam logic [6:0] TN_MAX = 7'h7f;

  // Priority levels of an active service
  localparam logic [2:0] PRI_NONE = 3'h0;
  localparam logic [2:0] PRI_CLASS_B = 3'h1;
  localparam logic [2:0] PRI_STACK_UNDERFLOW_FLAG = 3'h2;
  localparam logic [2:0] PRI_STACK_OVERFLOW_FLAG = 3'h3;
  localparam logic [2:0] PRI_NMI = 3'h4;

  localparam logic [15:0] RST_ZERO = 16'h0000;

  // Interrupt status bits of this block
  localparam int IRQ_TRAP = 0;
  localparam int IRQ_NODE = 1;
  localparam int IRQ_SW = 2;
  localparam int IRQ_BITS = 3;

  typedef enum logic [2:0] {
    TIVEC_IDLE = 3'b001,
    TIVEC_TRAP = 3'b010,
    TIVEC_IRQ = 3'b100
  } tivec_state_t;

  function automatic logic [8:0] tivec_vec(input logic [6:0] tn);
    tivec_vec = {tn, 2'b00};
  endfunction : tivec_vec
endpackage : tivec_pkg

// >>> tb/test_trap_and_interrupt_vectoring.sv
`timescale 1ns/1ps
module test_trap_and_interrupt_vectoring import tivec_pkg::*;;
  logic sys_clk = 0, reset_n = 0, soft_reset = 0, watchdog_overflow = 0;
  logic wr = 0, rd = 0, slow = 0, service_done, irq_a;
  logic [7:0] tev = 8'h00;
  logic [15:0] nev = 16'h0000, wdata = 16'h0000, rdata, rv;
  logic [3:0] addr = 4'h0;
  logic branch, branch_is_trap, cpu_reset, pec_block, irq;
  logic [8:0] branch_vector;
  logic [6:0] branch_trap;
  int failures = 0, comparisons = 0;
  int fbit [8] = '{FLG_NMI, FLG_STACK_OVERFLOW_FLAG, FLG_STACK_UNDERFLOW_FLAG, FLG_UNDEFINED_OPCODE_FLAG, FLG_PROTECTED_INSTRUCTION_FAULT_FLAG,
    FLG_ILLEGAL_WORD_OPERAND_FLAG, FLG_ILLEGAL_INSTRUCTION_FETCH_FLAG, FLG_ILLEGAL_EXTERNAL_BUS_FLAG};
  always #5 sys_clk = ~sys_clk;
  tivec_unit #(.NODES(16)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .soft_reset(soft_reset),
    .watchdog_overflow(watchdog_overflow), .nmi_event(tev[0]),
    .stack_overflow_event(tev[1]), .stack_underflow_event(tev[2]),
    .undefined_opcode_event(tev[3]), .protected_fault_event(tev[4]),
    .illegal_operand_event(tev[5]), .illegal_fetch_event(tev[6]),
    .illegal_bus_event(tev[7]), .node_event(nev),
    .service_done(service_done), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .branch(branch), .branch_vector(branch_vector),
    .branch_trap(branch_trap), .branch_is_trap(branch_is_trap),
    .cpu_reset(cpu_reset), .pec_block(pec_block), .irq(irq));
  tivec_seq_model seq_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .branch(branch),
    .branch_is_trap(branch_is_trap), .branch_trap(branch_trap),
    .service_done(service_done));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rreg
  task automatic tpulse(int i);
    @(posedge sys_clk);
    tev <= 8'h01 << i;
    @(posedge sys_clk);
    tev <= 8'h00;
    #1;
  endtask : tpulse
  // Bounded wait so a lost branch shows up as a mismatch, not a hang
  task automatic wait_branch(logic [6:0] t, logic k);
    int n;
    n = 0;
    while (branch !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("branch", branch, 1'b1);
    check("trap", branch_trap, t);
    check("vector", branch_vector, {t, 2'b00});
    check("is_trap", branch_is_trap, k);
  endtask : wait_branch
  task automatic wait_idle();
    int n;
    n = 0;
    while (pec_block !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("pec_block", pec_block, 1'b0);
  endtask : wait_idle
  task automatic t_traps();
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      tpulse(i);
      wait_branch(i < 3 ? TN_NMI + 7'(2 * i) : TN_CLASS_B, 1'b1);
      check("pec_block", pec_block, 1'b1);
      acc[fbit[i]] = 1'b1;
      wait_idle();
      rreg(REG_TRAP_FLAGS);
      check("flags", rv, acc);
    end
    wreg(REG_TRAP_FLAGS, 16'hffff);
    rreg(REG_TRAP_FLAGS);
    check("flags", rv, 16'h0000);
  endtask : t_traps
  task automatic t_resets();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      soft_reset <= (i == 0);
      watchdog_overflow <= (i == 1);
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      watchdog_overflow <= 1'b0;
      #1 check("cpu_reset", cpu_reset, 1'b1);
      wait_branch(TN_RESET, 1'b0);
      rreg(REG_TRAP_FLAGS);
      check("flags", rv, 16'h0000);
    end
  endtask : t_resets
  task automatic t_nodes();
    @(posedge sys_clk);
    nev <= 16'h0120;
    @(posedge sys_clk);
    nev <= 16'h0000;
    rreg(REG_NODE_REQ);
    check("branch", branch, 1'b0);
    check("node_req", rv, 16'h0120);
    wreg(REG_NODE_EN, 16'h0120);
    wait_branch(TN_NODE_BASE + 7'h05, 1'b0);
    @(posedge sys_clk);
    #1 wait_branch(7'h28, 1'b0);
    rreg(REG_NODE_REQ);
    check("node_req", rv, 16'h0000);
    wreg(REG_NODE_REQ, 16'h0004);
    rreg(REG_NODE_REQ);
    check("node_req", rv, 16'h0004);
    check("branch", branch, 1'b0);
    wreg(REG_NODE_REQ, 16'h0000);
    rreg(REG_NODE_REQ);
    check("node_req", rv, 16'h0000);
  endtask : t_nodes
  // Slow sequencer keeps each service open so the nesting can be seen
  task automatic t_nest();
    wreg(REG_NODE_EN, 16'h0008);
    slow <= 1'b1;
    tpulse(3);
    wait_branch(TN_CLASS_B, 1'b1);
    @(posedge sys_clk);
    nev <= 16'h0008;
    @(posedge sys_clk);
    nev <= 16'h0000;
    tpulse(0);
    wait_branch(TN_NMI, 1'b1);
    tpulse(2);
    check("branch", branch, 1'b0);
    check("pec_block", pec_block, 1'b1);
    wait_branch(TN_STACK_UNDERFLOW_FLAG, 1'b1);
    @(posedge sys_clk);
    #1 wait_branch(TN_NODE_BASE + 7'h03, 1'b0);
    slow <= 1'b0;
    wait_idle();
  endtask : t_nest
  task automatic t_sw();
    wreg(REG_SW_TRAP, 16'h007f);
    #1 wait_branch(TN_MAX, 1'b0);
    rreg(REG_VECTOR);
    check("vector_reg", rv, 16'h01fc);
    check("pec_block", pec_block, 1'b0);
    wreg(REG_SW_TRAP, 16'h0000);
    #1 wait_branch(7'h00, 1'b0);
  endtask : t_sw
  task automatic t_irq();
    wreg(REG_IRQ_MASK, 16'h0007);
    #1 irq_a = irq;
    wreg(REG_IRQ_MASK, 16'h0000);
    #1 check("irq_mask", irq ^ irq_a, 1'b1);
    wreg(REG_IRQ_STAT, 16'h0007);
    wreg(REG_TRAP_FLAGS, 16'hffff);
    rreg(REG_IRQ_STAT);
    check("irq_stat", rv, 16'h0000);
    check("irq", irq, 1'b0);
  endtask : t_irq
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 check("cpu_reset", cpu_reset, 1'b1);
    rreg(4'hc);
    check("unmapped", rv, 16'h0000);
    check("cpu_reset", cpu_reset, 1'b0);
    rreg(REG_TRAP_FLAGS);
    check("flags", rv, 16'h0000);
    t_traps();
    t_resets();
    t_nodes();
    t_nest();
    t_sw();
    t_irq();
    tally_and_finish();
  end
endmodule : test_trap_and_interrupt_vectoring

// >>> tb/tivec_seq_model.sv
`timescale 1ns/1ps
// Program sequencer stand-in: ends each trap or node service after a delay
module tivec_seq_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic branch,
  input wire logic branch_is_trap,
  input wire logic [6:0] branch_trap,
  output logic service_done
);
  logic [3:0] pend_ff;
  logic [4:0] wait_ff;
  logic take;
  logic done;
  // Resets, and software traps outside the node range, get no done
  assign take = branch && (branch_is_trap || branch_trap[6:4] == 3'h2);
  assign done = (pend_ff != 4'h0) && (wait_ff == (slow ? 5'h0c : 5'h02));
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= 4'h0;
      wait_ff <= 5'h00;
      service_done <= 1'b0;
    end else begin
      service_done <= done;
      pend_ff <= pend_ff + {3'h0, take} - {3'h0, done};
      wait_ff <= (done || pend_ff == 4'h0) ? 5'h00 : wait_ff + 5'h01;
    end
  end
endmodule : tivec_seq_model
